//--- can_afb_defines.svh
`ifndef CAN_AFB_DEFINES_SVH
`define CAN_AFB_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define CAN_AFB_ADDR_W 8
`define CAN_AFB_FILT_BASE 8'h00
`define CAN_AFB_CFG_BASE 8'h40
`define CAN_AFB_MODE_ADDR 8'h60
`define CAN_AFB_STAT_ADDR 8'h64

// ****************************************
// Field positions
// ****************************************
`define CAN_AFB_CFG_ACTIVE_BIT 0
`define CAN_AFB_CFG_SCALE_LSB 1
`define CAN_AFB_MODE_HIGH_LSB 8
`define CAN_AFB_STAT_INDEX_LSB 8
`define CAN_AFB_STAT_CNT_LSB 16

// ****************************************
// Reset values and constants
// ****************************************
`define CAN_AFB_BANKS 8
`define CAN_AFB_SCALE_RST 2'h0
`define CAN_AFB_CARE32 32'hfffffffe
`define CAN_AFB_CARE16 32'hfff80000
`define CAN_AFB_CARE8 32'hff000000
`define CAN_AFB_RESP_OKAY 2'h0
`define CAN_AFB_RESP_SLVERR 2'h2

`endif

//--- can_afb_pkg.sv
package can_afb_pkg;

  typedef enum logic [1:0] {CAN_AFB_W8, CAN_AFB_W16, CAN_AFB_W32} can_afb_width_t;

  typedef struct packed {
    logic [10:0] std_ident_bits;
    logic rtr;
    logic ide;
    logic [17:0] ext_ident_bits;
  } can_afb_ident_t;

  typedef struct packed {
    logic valid;
    logic [2:0] id_reg;
    logic [2:0] mask_reg;
    can_afb_width_t width;
    logic high_half;
  } can_afb_sub_t;

  typedef struct packed {
    logic hit;
    logic [1:0] cls;
    logic [2:0] local_idx;
    logic [3:0] used;
  } can_afb_bank_res_t;

endpackage : can_afb_pkg

//--- can_afb_bank.sv
`timescale 1ns/1ns
`include "can_afb_defines.svh"

module can_afb_bank
  import can_afb_pkg::*;
(
  // Bank configuration
  input wire logic [63:0] bank_filter_byte,
  input wire logic bank_active,
  input wire logic [1:0] bank_scale_sel,
  input wire logic low_half_list_mode,
  input wire logic high_half_list_mode,
  // Identifier and result
  input wire logic [31:0] key,
  output can_afb_bank_res_t res
);

  // ****************************************
  // Sub-filter layout per scale
  // ****************************************
  function automatic can_afb_sub_t sub_cfg(input logic [1:0] scale, input logic [1:0] k);
    can_afb_sub_t s;
    s = '0;
    unique case (scale)
      2'h3: if (k == 2'h0) s = '{1'b1, 3'h0, 3'h4, CAN_AFB_W32, 1'b0};
      2'h2: s = '{k < 2'h2, {k[0], 2'h0}, {k[0], 2'h2}, CAN_AFB_W16, k[0]};
      2'h1: begin
        if (k == 2'h0) s = '{1'b1, 3'h0, 3'h2, CAN_AFB_W16, 1'b0};
        else if (k != 2'h3) s = '{1'b1, {k, 1'b0} + 3'h2, {k, 1'b1} + 3'h2, CAN_AFB_W8, 1'b1};
      end
      2'h0: s = '{1'b1, {k, 1'b0}, {k, 1'b1}, CAN_AFB_W8, k[1]};
    endcase
    return s;
  endfunction : sub_cfg

  function automatic logic [31:0] bytes_at(input logic [63:0] b, input logic [2:0] s);
    return {b[8*s +: 8], b[8*(3'(s + 3'h1)) +: 8], b[8*(3'(s + 3'h2)) +: 8],
            b[8*(3'(s + 3'h3)) +: 8]};
  endfunction : bytes_at

  // ****************************************
  // Match and local priority
  // ****************************************
  can_afb_sub_t cfg;
  logic [31:0] care;
  logic [31:0] idv;
  logic [31:0] mv;
  logic list_mode;
  logic [1:0] cls;
  logic m0;
  logic m1;
  logic [3:0] n;

  always_comb begin
    res = '0;
    n = '0;
    cfg = '0;
    care = '0;
    idv = '0;
    mv = '0;
    list_mode = 1'b0;
    cls = '0;
    m0 = 1'b0;
    m1 = 1'b0;
    for (int k = 0; k < 4; k++) begin
      cfg = sub_cfg(bank_scale_sel, 2'(k));
      if (cfg.valid) begin
        unique case (cfg.width)
          CAN_AFB_W32: care = `CAN_AFB_CARE32;
          CAN_AFB_W16: care = `CAN_AFB_CARE16;
          default: care = `CAN_AFB_CARE8;
        endcase
        idv = bytes_at(bank_filter_byte, cfg.id_reg);
        mv = bytes_at(bank_filter_byte, cfg.mask_reg);
        list_mode = cfg.high_half ? high_half_list_mode : low_half_list_mode;
        cls = {list_mode, cfg.width != CAN_AFB_W8};
        if (list_mode) begin
          m0 = ((key ^ idv) & care) == 32'h0;
          m1 = ((key ^ mv) & care) == 32'h0;
        end else begin
          m0 = ((key ^ idv) & mv & care) == 32'h0;
          m1 = 1'b0;
        end
        if (bank_active && m0 && (!res.hit || cls > res.cls)) begin
          res.hit = 1'b1;
          res.cls = cls;
          res.local_idx = n[2:0];
        end
        if (bank_active && m1 && (!res.hit || cls > res.cls)) begin
          res.hit = 1'b1;
          res.cls = cls;
          res.local_idx = 3'(n + 4'h1);
        end
        n = n + (list_mode ? 4'h2 : 4'h1);
      end
    end
    res.used = n;
  end

endmodule : can_afb_bank

//--- can_afb_top.sv
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "can_afb_defines.svh"

module can_afb_top
  import can_afb_pkg::*;
#(
  parameter int BANKS = `CAN_AFB_BANKS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic [`CAN_AFB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`CAN_AFB_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Received identifier
  input wire logic id_valid,
  input wire can_afb_ident_t id_in,
  // Filter result
  output logic store_valid,
  output logic [5:0] match_index_slot,
  output logic discard_valid
);

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] filt_reg [0:2*BANKS-1];
  logic [BANKS-1:0] active_reg;
  logic [1:0] scale_reg [0:BANKS-1];
  logic [BANKS-1:0] low_list_reg;
  logic [BANKS-1:0] high_list_reg;
  logic last_accept_reg;
  logic [5:0] last_index_reg;
  logic [15:0] accept_cnt_reg;

  // ****************************************
  // Write channel
  // ****************************************
  logic aw_full_reg;
  logic w_full_reg;
  logic [`CAN_AFB_ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  wire aw_take = s_axi_awvalid & awready_reg;
  wire w_take = s_axi_wvalid & wready_reg;
  wire aw_full_next = aw_full_reg | aw_take;
  wire w_full_next = w_full_reg | w_take;
  wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
  wire aw_hold_next = aw_full_next & ~do_write;
  wire w_hold_next = w_full_next & ~do_write;
  wire wr_is_filt = aw_addr_reg[7:6] == 2'h0;
  wire wr_is_cfg = aw_addr_reg[7:5] == `CAN_AFB_CFG_BASE >> 5;
  wire wr_is_mode = aw_addr_reg[7:2] == `CAN_AFB_MODE_ADDR >> 2;
  wire wr_is_stat = aw_addr_reg[7:2] == `CAN_AFB_STAT_ADDR >> 2;
  wire wr_ok = wr_is_filt | wr_is_cfg | wr_is_mode | wr_is_stat;
  wire [3:0] wr_word = aw_addr_reg[5:2];
  wire [2:0] wr_bank = aw_addr_reg[4:2];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `CAN_AFB_RESP_OKAY;
    end else begin
      aw_full_reg <= aw_hold_next;
      w_full_reg <= w_hold_next;
      awready_reg <= ~aw_hold_next & ~bvalid_next;
      wready_reg <= ~w_hold_next & ~bvalid_next;
      bvalid_reg <= bvalid_next;
      if (do_write) bresp_reg <= wr_ok ? `CAN_AFB_RESP_OKAY : `CAN_AFB_RESP_SLVERR;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (aw_take) aw_addr_reg <= s_axi_awaddr;
    if (w_take) begin
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
  end

  // ****************************************
  // Register file writes
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 2*BANKS; i++) filt_reg[i] <= 32'h0;
      for (int i = 0; i < BANKS; i++) scale_reg[i] <= `CAN_AFB_SCALE_RST;
      active_reg <= '0;
      low_list_reg <= '0;
      high_list_reg <= '0;
    end else if (do_write) begin
      for (int l = 0; l < 4; l++) begin
        if (wr_is_filt && w_strb_reg[l]) filt_reg[wr_word][8*l +: 8] <= w_data_reg[8*l +: 8];
      end
      if (wr_is_cfg && w_strb_reg[0]) begin
        active_reg[wr_bank] <= w_data_reg[`CAN_AFB_CFG_ACTIVE_BIT];
        scale_reg[wr_bank] <= w_data_reg[`CAN_AFB_CFG_SCALE_LSB +: 2];
      end
      if (wr_is_mode && w_strb_reg[0]) low_list_reg <= w_data_reg[BANKS-1:0];
      if (wr_is_mode && w_strb_reg[1]) high_list_reg <= w_data_reg[`CAN_AFB_MODE_HIGH_LSB +: BANKS];
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  wire ar_take = s_axi_arvalid & arready_reg;
  wire rd_is_filt = s_axi_araddr[7:6] == 2'h0;
  wire rd_is_cfg = s_axi_araddr[7:5] == `CAN_AFB_CFG_BASE >> 5;
  wire rd_is_mode = s_axi_araddr[7:2] == `CAN_AFB_MODE_ADDR >> 2;
  wire rd_is_stat = s_axi_araddr[7:2] == `CAN_AFB_STAT_ADDR >> 2;
  wire rd_ok = rd_is_filt | rd_is_cfg | rd_is_mode | rd_is_stat;
  wire [2:0] rd_bank = s_axi_araddr[4:2];
  wire [31:0] rd_cfg = {29'h0, scale_reg[rd_bank], active_reg[rd_bank]};
  wire [31:0] rd_mode = {16'h0, high_list_reg, low_list_reg};
  wire [31:0] rd_stat = {accept_cnt_reg, 2'h0, last_index_reg, 7'h0, last_accept_reg};
  wire [31:0] rd_data = rd_is_filt ? filt_reg[s_axi_araddr[5:2]] :
                        rd_is_cfg ? rd_cfg :
                        rd_is_mode ? rd_mode :
                        rd_is_stat ? rd_stat : 32'h0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `CAN_AFB_RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_data;
      rresp_reg <= rd_ok ? `CAN_AFB_RESP_OKAY : `CAN_AFB_RESP_SLVERR;
    end else begin
      rvalid_reg <= rvalid_reg & ~s_axi_rready;
      arready_reg <= ~(rvalid_reg & ~s_axi_rready);
    end
  end

  // ****************************************
  // Filter banks
  // ****************************************
  wire [31:0] key = {id_in.std_ident_bits, id_in.rtr, id_in.ide, id_in.ext_ident_bits, 1'b0};
  can_afb_bank_res_t bank_res [0:BANKS-1];
  logic [6:0] base [0:BANKS];

  assign base[0] = 7'h0;

  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    can_afb_bank u_bank (
      .bank_filter_byte({filt_reg[2*b+1], filt_reg[2*b]}),
      .bank_active(active_reg[b]),
      .bank_scale_sel(scale_reg[b]),
      .low_half_list_mode(low_list_reg[b]),
      .high_half_list_mode(high_list_reg[b]),
      .key(key),
      .res(bank_res[b])
    );
    assign base[b+1] = base[b] + {3'h0, bank_res[b].used};
  end

  // ****************************************
  // Priority across banks
  // ****************************************
  logic best_hit;
  logic [1:0] best_cls;
  logic [5:0] best_idx;

  always_comb begin
    best_hit = 1'b0;
    best_cls = 2'h0;
    best_idx = 6'h0;
    for (int b = 0; b < BANKS; b++) begin
      if (bank_res[b].hit && (!best_hit || bank_res[b].cls > best_cls)) begin
        best_hit = 1'b1;
        best_cls = bank_res[b].cls;
        best_idx = 6'(base[b] + {4'h0, bank_res[b].local_idx});
      end
    end
  end

  // ****************************************
  // Result and status
  // ****************************************
  logic store_valid_reg;
  logic discard_valid_reg;
  logic [5:0] index_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      store_valid_reg <= 1'b0;
      discard_valid_reg <= 1'b0;
      index_reg <= 6'h0;
      last_accept_reg <= 1'b0;
      last_index_reg <= 6'h0;
      accept_cnt_reg <= 16'h0;
    end else begin
      store_valid_reg <= id_valid & best_hit;
      discard_valid_reg <= id_valid & ~best_hit;
      if (id_valid && best_hit) begin
        index_reg <= best_idx;
        last_accept_reg <= 1'b1;
        last_index_reg <= best_idx;
        accept_cnt_reg <= accept_cnt_reg + 16'h1;
      end else if (id_valid) begin
        last_accept_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign store_valid = store_valid_reg;
  assign discard_valid = discard_valid_reg;
  assign match_index_slot = index_reg;

endmodule : can_afb_top

//--- cafb_rx_model.sv
`timescale 1ns/1ns

module cafb_rx_model
  import can_afb_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Identifier out
  output logic id_valid,
  output can_afb_ident_t id_in
);
  // ****************************************
  // Frame source
  // ****************************************
  initial begin
    id_valid = 1'h0;
    id_in = '0;
  end

  // One cycle per frame; idle lines show the inverse of the last value
  task automatic send_frame(input can_afb_ident_t id, input logic last);
    id_valid <= 1'h1;
    id_in <= id;
    @(posedge ref_clk);
    if (last) begin
      id_valid <= 1'h0;
      id_in <= ~id;
    end
  endtask : send_frame
endmodule : cafb_rx_model

//--- cafb_chk.sv
`timescale 1ns/1ns

module cafb_chk #(
  parameter int BANKS = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Filter path
  input wire logic id_valid,
  input wire logic store_valid,
  input wire logic [5:0] match_index_slot,
  input wire logic discard_valid
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_one_result;
    id_valid |=> store_valid ^ discard_valid;
  endproperty
  a_one_result: assert property (p_one_result) else $error("no single result");
  property p_no_spurious;
    !id_valid |=> !store_valid && !discard_valid;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("result without frame");
  property p_index_held;
    !store_valid |-> $stable(match_index_slot);
  endproperty
  a_index_held: assert property (p_index_held) else $error("index moved");
  property p_index_range;
    store_valid |-> {1'b0, match_index_slot} < 7'(BANKS * 8);
  endproperty
  a_index_range: assert property (p_index_range) else $error("index range");
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("rvalid dropped");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##[0:2] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_err_data;
    s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data) else $error("error read data");
  c_store: cover property (store_valid);
  c_discard: cover property (discard_valid);
  c_back: cover property (id_valid ##1 id_valid);
endmodule : cafb_chk

//--- can_acceptance_filter_banks_tb.sv
`timescale 1ns/1ns

module can_acceptance_filter_banks_tb
  import can_afb_pkg::*;
;
  typedef struct packed {
    logic [1:0] sc;
    logic lm;
    logic hm;
    logic [63:0] r;
    logic [30:0] id;
    logic st;
    logic [5:0] ix;
  } cafb_row_t;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic id_valid, store_valid, discard_valid;
  can_afb_ident_t id_in;
  logic [5:0] match_index_slot;
  int err_total = 0;
  int total_checks = 0;
  int acc_cnt = 0;
  cafb_row_t rows [9] = '{
    '{2'h3, 1'h0, 1'h0, 64'hb4600000_fffffffe, 31'h5a300000, 1'h1, 6'h0},
    '{2'h3, 1'h0, 1'h0, 64'hb4600000_ffffff00, 31'h5a30007f, 1'h1, 6'h0},
    '{2'h3, 1'h0, 1'h0, 64'hb4600000_fffffffe, 31'h5a200000, 1'h0, 6'h0},
    '{2'h3, 1'h1, 1'h1, 64'h11223344_b4600000, 31'h5a300000, 1'h1, 6'h1},
    '{2'h2, 1'h0, 1'h0, 64'h0000ffff_b460ffff, 31'h5a33ffff, 1'h1, 6'h1},
    '{2'h2, 1'h1, 1'h0, 64'h1234b460_0000fff8, 31'h5a300000, 1'h1, 6'h1},
    '{2'h0, 1'h0, 1'h0, 64'h00ff00ff_b4ff00ff, 31'h5a33ffff, 1'h1, 6'h2},
    '{2'h0, 1'h0, 1'h1, 64'h00ff00ff_11b400ff, 31'h5a300000, 1'h1, 6'h3},
    '{2'h1, 1'h0, 1'h0, 64'h0000fff8_00ffb4ff, 31'h5a300000, 1'h1, 6'h2}
  };

  can_afb_top u_dut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .id_valid, .id_in, .store_valid,
    .match_index_slot, .discard_valid);
  cafb_rx_model u_rx (.ref_clk, .id_valid, .id_in);

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n > 50) begin
      err_total++;
      $display("Error timeout waiting on bus");
      complete_run();
    end
  endtask : tmo

  function automatic logic [31:0] swp(input logic [31:0] k);
    return {k[7:0], k[15:8], k[23:16], k[31:24]};
  endfunction : swp

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ad, dd;
    n = 0;
    ad = 1'h0;
    dd = 1'h0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ad && dd)) begin
      @(negedge ref_clk);
      ad = ad || s_axi_awready;
      dd = dd || s_axi_wready;
      @(posedge ref_clk);
      if (ad) s_axi_awvalid <= 1'h0;
      if (dd) s_axi_wvalid <= 1'h0;
      n++;
      tmo(n);
    end
    while (s_axi_bvalid !== 1'h1) begin
      @(negedge ref_clk);
      n++;
      tmo(n);
    end
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge ref_clk);
    s_axi_bready <= 1'h0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge ref_clk);
      n++;
      tmo(n);
    end while (s_axi_arready !== 1'h1);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'h0;
    do begin
      @(negedge ref_clk);
      n++;
      tmo(n);
    end while (s_axi_rvalid !== 1'h1);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    chk("rdata", ex, s_axi_rdata);
    @(posedge ref_clk);
    s_axi_rready <= 1'h0;
  endtask : axi_rd

  task automatic run_id(input can_afb_ident_t id, input logic last, input logic st,
                        input logic [5:0] ix);
    u_rx.send_frame(id, last);
    #1;
    chk("store_valid", {31'h0, st}, {31'h0, store_valid});
    chk("discard_valid", {31'h0, !st}, {31'h0, discard_valid});
    if (st) begin
      acc_cnt++;
      chk("match_index_slot", {26'h0, ix}, {26'h0, match_index_slot});
    end
  endtask : run_id

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'h0;
    axi_rd(8'h40, 32'h0, 2'h0);
    axi_rd(8'h70, 32'h0, 2'h2);
    axi_wr(8'h70, 32'h1, 2'h2);
    for (int i = 0; i < 9; i++) begin
      axi_wr(8'h40, 32'h0, 2'h0);
      axi_wr(8'h60, {16'h0, 7'h0, rows[i].hm, 7'h0, rows[i].lm}, 2'h0);
      axi_wr(8'h00, swp(rows[i].r[63:32]), 2'h0);
      axi_wr(8'h04, swp(rows[i].r[31:0]), 2'h0);
      axi_wr(8'h40, {29'h0, rows[i].sc, 1'h1}, 2'h0);
      run_id(rows[i].id, 1'h1, rows[i].st, rows[i].ix);
    end
    axi_wr(8'h40, 32'h0, 2'h0);
    axi_wr(8'h60, 32'h0, 2'h0);
    axi_wr(8'h00, 32'h0, 2'h0);
    axi_wr(8'h04, 32'h0, 2'h0);
    axi_wr(8'h40, 32'h1, 2'h0);
    run_id(31'h5a300000, 1'h1, 1'h1, 6'h0);
    axi_wr(8'h44, 32'h5, 2'h0);
    axi_rd(8'h44, 32'h5, 2'h0);
    run_id(31'h5a300000, 1'h1, 1'h1, 6'h4);
    axi_wr(8'h60, 32'h0404, 2'h0);
    axi_wr(8'h10, swp(32'hb4600000), 2'h0);
    axi_wr(8'h48, 32'h7, 2'h0);
    run_id(31'h5a300000, 1'h0, 1'h1, 6'h6);
    run_id(31'h5a200000, 1'h1, 1'h1, 6'h4);
    axi_rd(8'h64, {acc_cnt[15:0], 2'h0, 6'h4, 7'h0, 1'h1}, 2'h0);
    axi_wr(8'h40, 32'h0, 2'h0);
    axi_wr(8'h44, 32'h0, 2'h0);
    axi_wr(8'h48, 32'h0, 2'h0);
    run_id(31'h5a300000, 1'h1, 1'h0, 6'h0);
    @(posedge ref_clk);
    rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    chk("match_index_slot", 32'h0, {26'h0, match_index_slot});
    axi_rd(8'h64, 32'h0, 2'h0);
    axi_rd(8'h60, 32'h0, 2'h0);
    complete_run();
  end
endmodule : can_acceptance_filter_banks_tb

bind can_afb_top cafb_chk #(.BANKS(BANKS)) u_chk (.ref_clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .id_valid, .store_valid, .match_index_slot, .discard_valid);
